/* File: sysctl_apb_host.sv */
`timescale 1ns/1ps
// ============================================================
// Host side model: the core or debug path issuing APB transfers.
module sysctl_apb_host (
  input  wire logic        i_core_clk,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr,
  input  wire logic [31:0] i_prdata,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [7:0]       o_paddr,
  output logic [31:0]      o_pwdata
);
  // The bus idles with the select low from time zero.
  initial
  begin
    o_psel    = 1'b0;
    o_penable = 1'b0;
    o_pwrite  = 1'b0;
    o_paddr   = 8'h00;
    o_pwdata  = 32'h0000_0000;
  end

  // One transfer: setup, then access held until pready is seen high; addresses 0x3C to 0x3F get an error flag and no transfer.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    rd  = 32'h0000_0000;
    err = 1'b1;
    if (a[7:2] == 6'h0F) return;
    @(posedge i_core_clk);
    o_psel   <= 1'b1;
    o_pwrite <= wr;
    o_paddr  <= a;
    o_pwdata <= wd;
    @(posedge i_core_clk);
    o_penable <= 1'b1;
    // Only the bench watchdog ends a wait for the answer.
    do
    begin
      @(posedge i_core_clk);
    end
    while (i_pready !== 1'b1);
    rd  = i_prdata;
    err = i_pslverr;
    o_psel    <= 1'b0;
    o_penable <= 1'b0;
    o_paddr   <= ~a;  // Released address and data lines do not keep their last value.
    o_pwdata  <= ~wd;
  endtask : xfer
endmodule : sysctl_apb_host

/* File: sysctl_coproc_defs.svh */
`ifndef SYSCTL_COPROC_DEFS_SVH
`define SYSCTL_COPROC_DEFS_SVH
// ============================================================
// Bus map: coprocessor register n sits at byte offset 4*n.
`define SC_CP_WINDOW_BIT   6
`define SC_SEL_OFS         8'h40
// ============================================================
// Coprocessor register numbers.
`define SC_CP_ID           4'h0
`define SC_CP_CTRL         4'h1
`define SC_CP_CACHE        4'h2
`define SC_CP_BUF          4'h3
`define SC_CP_PROT         4'h5
`define SC_CP_REGION       4'h6
`define SC_CP_CACHEOP      4'h7
`define SC_CP_LOCK         4'h9
`define SC_CP_TRACE        4'hD
// ============================================================
// Bank selector values.
`define SC_BANK_0          2'h0
`define SC_BANK_1          2'h1
`define SC_BANK_2          2'h2
`define SC_BANK_3          2'h3
// ============================================================
// Cache operation codes in write data bits [2:0].
`define SC_OPC_LSB         0
`define SC_OPC_MSB         2
`define SC_OPA_LSB         3
`define SC_OPC_0           3'h0
`define SC_OPC_1           3'h1
`define SC_OPC_2           3'h2
`define SC_OPC_3           3'h3
`define SC_OPC_4           3'h4
`define SC_OPC_5           3'h5
// ============================================================
// Reset values.
`define SC_WORD_RST        32'h0000_0000
`define SC_SEL_RST         5'h00
`endif

/* File: sysctl_coproc_pkg.sv */
package sysctl_coproc_pkg;

  // Access selection: region index above bank selector.
  typedef struct packed {
    logic [2:0] region_index;
    logic [1:0] bank_selector;
  } sel_t;

  // Cache maintenance operations.
  typedef enum logic [3:0] {
    OP_NONE             = 4'h0,
    OP_DC_FLUSH_ALL     = 4'h1,
    OP_DC_FLUSH_VA      = 4'h2,
    OP_DC_CLEAN_VA      = 4'h3,
    OP_DC_CLEAN_FLUSH_VA = 4'h4,
    OP_DC_CLEAN_IDX     = 4'h5,
    OP_DC_CLEAN_FLUSH_IDX = 4'h6,
    OP_IC_FLUSH_ALL     = 4'h7,
    OP_IC_FLUSH_VA      = 4'h8,
    OP_IC_PREFETCH      = 4'h9
  } cache_op_t;

  // One-cycle cache command toward the cache controller.
  typedef struct packed {
    logic        valid;
    cache_op_t   op;
    logic [31:0] operand;
  } cache_cmd_t;

endpackage : sysctl_coproc_pkg

/* File: sysctl_coproc_reg_decode.sv */
`timescale 1ns/1ps
`include "sysctl_coproc_defs.svh"

// Contract
// - Register 0 read, bank 0, returns the identification value.
// - Register 0 read, bank 1, returns the cache configuration value.
// - Register 0 read, bank 2, returns the tightly coupled memory information.
// - Registers 1, 3 and 13 are plain storage regardless of bank.
// - Register 2 with bank 0 or 2 reaches data cache control.
// - Register 2 with bank 1 or 3 reaches instruction cache control.
// - Register 5 with bank 0 or 2 reaches data protection permissions.
// - Register 5 with bank 1 reaches instruction protection permissions.
// - Eight region definitions, each readable and writable through register 6.
// - Register 6 picks the region by region index only; one shared set.
// - Register 7 is write-only; a write with a listed bank and code starts an operation.
// - Bank 0 codes 000 to 101 select the six data cache operations.
// - Bank 1 codes 000 to 010 select the three instruction cache operations.
// - Operation operand is write data bits [31:3] with low bits zero.
// - Register 9 bank 0 reaches data lockdown, bank 1 instruction lockdown.
// - Register 9 bank 2 and 3 reach the tightly coupled memory controls.
module sysctl_coproc_reg_decode #(
  parameter int          NUM_REGIONS     = 8,
  parameter logic [31:0] ID_VALUE        = 32'h0000_0001, // Arbitrary value.
  parameter logic [31:0] CACHE_CFG_VALUE = 32'h0000_0002, // Arbitrary value.
  parameter logic [31:0] TCM_INFO_VALUE  = 32'h0000_0003  // Arbitrary value.
) (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_resetn,
  input  wire logic                      i_psel,
  input  wire logic                      i_penable,
  input  wire logic                      i_pwrite,
  input  wire logic [7:0]                i_paddr,
  input  wire logic [31:0]               i_pwdata,
  output logic                           o_pready,
  output logic                           o_pslverr,
  output logic [31:0]                    o_prdata,
  output sysctl_coproc_pkg::cache_cmd_t  o_cache_cmd
);
  import sysctl_coproc_pkg::*;

  // Elaboration check on the region count.
  if (NUM_REGIONS < 1 || NUM_REGIONS > 8)
  begin : g_bad_regions
    $error("NUM_REGIONS must lie between 1 and 8.");
  end

  localparam logic [3:0] NREG = 4'(NUM_REGIONS);

  // ============================================================
  // Declarations.
  logic        pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  cache_cmd_t  cmd_q, cmd_d;
  sel_t        sel_q, sel_d;
  logic [31:0] ctrl_q, ctrl_d, buf_q, buf_d, trace_q, trace_d;
  logic [31:0] dcache_q, dcache_d, icache_q, icache_d;
  logic [31:0] dprot_q, dprot_d, iprot_q, iprot_d;
  logic [31:0] dlock_q, dlock_d, ilock_q, ilock_d;
  logic [31:0] dtcm_q, dtcm_d, itcm_q, itcm_d;
  logic [31:0] region_q [NUM_REGIONS];
  logic [31:0] region_d [NUM_REGIONS];
  logic        acc_wait, commit, cp_hit, sel_hit, region_ok;
  logic        rd_ok, wr_ok, wr_cp, wr_sel;
  logic [3:0]  cp_num;
  logic [1:0]  bank;
  logic [31:0] rd_val;
  cache_op_t   op_dec;

  // ============================================================
  // Bus phase decode.
  // Access waits one cycle so that read data comes from a flip-flop.
  assign acc_wait  = i_psel & i_penable & ~pready_q;
  assign commit    = i_psel & i_penable & pready_q;
  assign cp_hit    = ~i_paddr[`SC_CP_WINDOW_BIT] & ~i_paddr[7];
  assign sel_hit   = (i_paddr == `SC_SEL_OFS);
  assign cp_num    = i_paddr[5:2];
  assign bank      = sel_q.bank_selector;
  assign region_ok = ({1'b0, sel_q.region_index} < NREG);
  assign wr_cp     = commit & i_pwrite & cp_hit & wr_ok;
  assign wr_sel    = commit & i_pwrite & sel_hit;

  // Register selection by coprocessor number and bank selector.
  always_comb
  begin
    rd_val = `SC_WORD_RST;
    rd_ok  = 1'b0;
    wr_ok  = 1'b0;
    if (sel_hit)
    begin
      rd_val = {27'h000_0000, sel_q};
      rd_ok  = 1'b1;
      wr_ok  = 1'b1;
    end
    else if (cp_hit)
    begin
      case (cp_num)
        `SC_CP_ID:
        begin
          rd_ok = (bank != `SC_BANK_3);
          if (bank == `SC_BANK_0) rd_val = ID_VALUE;
          if (bank == `SC_BANK_1) rd_val = CACHE_CFG_VALUE;
          if (bank == `SC_BANK_2) rd_val = TCM_INFO_VALUE;
        end
        `SC_CP_CTRL:
        begin
          rd_val = ctrl_q;
          rd_ok  = 1'b1;
          wr_ok  = 1'b1;
        end
        `SC_CP_BUF:
        begin
          rd_val = buf_q;
          rd_ok  = 1'b1;
          wr_ok  = 1'b1;
        end
        `SC_CP_TRACE:
        begin
          rd_val = trace_q;
          rd_ok  = 1'b1;
          wr_ok  = 1'b1;
        end
        `SC_CP_CACHE:
        begin
          rd_val = bank[0] ? icache_q : dcache_q;
          rd_ok  = 1'b1;
          wr_ok  = 1'b1;
        end
        `SC_CP_PROT:
        begin
          rd_ok  = (bank != `SC_BANK_3);
          wr_ok  = rd_ok;
          rd_val = (bank == `SC_BANK_1) ? iprot_q : dprot_q;
        end
        `SC_CP_REGION:
        begin
          rd_ok = region_ok;
          wr_ok = region_ok;
          if (region_ok) rd_val = region_q[sel_q.region_index];
        end
        `SC_CP_CACHEOP:
        begin
          wr_ok = 1'b1;
        end
        `SC_CP_LOCK:
        begin
          rd_ok = 1'b1;
          wr_ok = 1'b1;
          case (bank)
            `SC_BANK_0: rd_val = dlock_q;
            `SC_BANK_1: rd_val = ilock_q;
            `SC_BANK_2: rd_val = dtcm_q;
            default:    rd_val = itcm_q;
          endcase
        end
        default:
        begin
          rd_ok = 1'b0;
        end
      endcase
    end
  end

  // Cache operation map; unlisted combinations give no operation.
  always_comb
  begin
    op_dec = OP_NONE;
    if (bank == `SC_BANK_0)
    begin
      case (i_pwdata[`SC_OPC_MSB:`SC_OPC_LSB])
        `SC_OPC_0: op_dec = OP_DC_FLUSH_ALL;
        `SC_OPC_1: op_dec = OP_DC_FLUSH_VA;
        `SC_OPC_2: op_dec = OP_DC_CLEAN_VA;
        `SC_OPC_3: op_dec = OP_DC_CLEAN_FLUSH_VA;
        `SC_OPC_4: op_dec = OP_DC_CLEAN_IDX;
        `SC_OPC_5: op_dec = OP_DC_CLEAN_FLUSH_IDX;
        default:   op_dec = OP_NONE;
      endcase
    end
    else if (bank == `SC_BANK_1)
    begin
      case (i_pwdata[`SC_OPC_MSB:`SC_OPC_LSB])
        `SC_OPC_0: op_dec = OP_IC_FLUSH_ALL;
        `SC_OPC_1: op_dec = OP_IC_FLUSH_VA;
        `SC_OPC_2: op_dec = OP_IC_PREFETCH;
        default:   op_dec = OP_NONE;
      endcase
    end
  end

  // ============================================================
  // Bus answer and cache command: next values.
  always_comb
  begin
    pready_d  = acc_wait;
    pslverr_d = 1'b0;
    prdata_d  = `SC_WORD_RST;
    if (acc_wait)
    begin
      pslverr_d = i_pwrite ? ~wr_ok : ~rd_ok;
      prdata_d  = i_pwrite ? `SC_WORD_RST : rd_val;
    end
    cmd_d       = '0;
    cmd_d.op    = OP_NONE;
    if (wr_cp && cp_num == `SC_CP_CACHEOP && op_dec != OP_NONE)
    begin
      cmd_d.valid   = 1'b1;
      cmd_d.op      = op_dec;
      cmd_d.operand = {i_pwdata[31:`SC_OPA_LSB], 3'h0};
    end
  end

  // Bus answer and cache command: registers.
  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= `SC_WORD_RST;
      cmd_q     <= '0;
    end
    else
    begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
      cmd_q     <= cmd_d;
    end
  end

  assign o_pready    = pready_q;
  assign o_pslverr   = pslverr_q;
  assign o_prdata    = prdata_q;
  assign o_cache_cmd = cmd_q;

  // ============================================================
  // Storage: next values, written only at the committing edge.
  always_comb
  begin
    sel_d    = wr_sel ? sel_t'(i_pwdata[4:0]) : sel_q;
    ctrl_d   = ctrl_q;
    buf_d    = buf_q;
    trace_d  = trace_q;
    dcache_d = dcache_q;
    icache_d = icache_q;
    dprot_d  = dprot_q;
    iprot_d  = iprot_q;
    dlock_d  = dlock_q;
    ilock_d  = ilock_q;
    dtcm_d   = dtcm_q;
    itcm_d   = itcm_q;
    region_d = region_q;
    if (wr_cp)
    begin
      case (cp_num)
        `SC_CP_CTRL:   ctrl_d  = i_pwdata;
        `SC_CP_BUF:    buf_d   = i_pwdata;
        `SC_CP_TRACE:  trace_d = i_pwdata;
        `SC_CP_CACHE:
        begin
          if (bank[0]) icache_d = i_pwdata;
          else         dcache_d = i_pwdata;
        end
        `SC_CP_PROT:
        begin
          if (bank == `SC_BANK_1) iprot_d = i_pwdata;
          else                    dprot_d = i_pwdata;
        end
        `SC_CP_REGION: region_d[sel_q.region_index] = i_pwdata;
        `SC_CP_LOCK:
        begin
          case (bank)
            `SC_BANK_0: dlock_d = i_pwdata;
            `SC_BANK_1: ilock_d = i_pwdata;
            `SC_BANK_2: dtcm_d  = i_pwdata;
            default:    itcm_d  = i_pwdata;
          endcase
        end
        default: ;
      endcase
    end
  end

  // Storage: registers.
  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      sel_q    <= sel_t'(`SC_SEL_RST);
      ctrl_q   <= `SC_WORD_RST;
      buf_q    <= `SC_WORD_RST;
      trace_q  <= `SC_WORD_RST;
      dcache_q <= `SC_WORD_RST;
      icache_q <= `SC_WORD_RST;
      dprot_q  <= `SC_WORD_RST;
      iprot_q  <= `SC_WORD_RST;
      dlock_q  <= `SC_WORD_RST;
      ilock_q  <= `SC_WORD_RST;
      dtcm_q   <= `SC_WORD_RST;
      itcm_q   <= `SC_WORD_RST;
      for (int i = 0; i < NUM_REGIONS; i++) region_q[i] <= `SC_WORD_RST;
    end
    else
    begin
      sel_q    <= sel_d;
      ctrl_q   <= ctrl_d;
      buf_q    <= buf_d;
      trace_q  <= trace_d;
      dcache_q <= dcache_d;
      icache_q <= icache_d;
      dprot_q  <= dprot_d;
      iprot_q  <= iprot_d;
      dlock_q  <= dlock_d;
      ilock_q  <= ilock_d;
      dtcm_q   <= dtcm_d;
      itcm_q   <= itcm_d;
      region_q <= region_d;
    end
  end

  // ============================================================
  // Checks.
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  logic rd0;
  assign rd0 = acc_wait & ~i_pwrite & cp_hit & (cp_num == `SC_CP_ID);

  chk_id_read: assert property (rd0 && bank == `SC_BANK_0 |=> o_pready && o_prdata == ID_VALUE)
    else $error("Identification read returned a wrong value.");
  chk_cfg_read: assert property (rd0 && bank == `SC_BANK_1 |=> o_prdata == CACHE_CFG_VALUE)
    else $error("Cache configuration read returned a wrong value.");
  chk_tcm_read: assert property (rd0 && bank == `SC_BANK_2 |=> o_prdata == TCM_INFO_VALUE)
    else $error("Memory information read returned a wrong value.");
  chk_ctrl_store: assert property (wr_cp && cp_num == `SC_CP_CTRL |=> ctrl_q == $past(i_pwdata))
    else $error("Control register write was not stored.");
  chk_dcache_sel: assert property (wr_cp && cp_num == `SC_CP_CACHE && !bank[0] |=> dcache_q == $past(i_pwdata)
    && $stable(icache_q))
    else $error("Data cache control write went astray.");
  chk_icache_sel: assert property (wr_cp && cp_num == `SC_CP_CACHE && bank[0] |=> icache_q == $past(i_pwdata))
    else $error("Instruction cache control write went astray.");
  chk_dprot_sel: assert property (wr_cp && cp_num == `SC_CP_PROT && bank == `SC_BANK_2 |=> dprot_q == $past(i_pwdata))
    else $error("Data protection write went astray.");
  chk_iprot_sel: assert property (wr_cp && cp_num == `SC_CP_PROT && bank == `SC_BANK_1 |=> $stable(dprot_q))
    else $error("Instruction protection write touched data side.");
  chk_region_rd: assert property (acc_wait && !i_pwrite && cp_hit && cp_num == `SC_CP_REGION && region_ok
    |=> o_prdata == region_q[sel_q.region_index])
    else $error("Region read returned a wrong value.");
  chk_op_wronly: assert property (acc_wait && !i_pwrite && cp_hit && cp_num == `SC_CP_CACHEOP |=> o_pslverr)
    else $error("Read of the operation register was not refused.");
  chk_dc_index: assert property (wr_cp && cp_num == `SC_CP_CACHEOP && bank == `SC_BANK_0
    && i_pwdata[2:0] == `SC_OPC_4 |=> o_cache_cmd.valid && o_cache_cmd.op == OP_DC_CLEAN_IDX)
    else $error("Clean by index was not issued.");
  chk_ic_fetch: assert property (wr_cp && cp_num == `SC_CP_CACHEOP && bank == `SC_BANK_1
    && i_pwdata[2:0] == `SC_OPC_2 |=> o_cache_cmd.op == OP_IC_PREFETCH)
    else $error("Prefetch was not issued.");
  chk_operand: assert property (o_cache_cmd.valid |-> o_cache_cmd.operand[2:0] == 3'h0
    && o_cache_cmd.operand[31:3] == $past(i_pwdata[31:3]))
    else $error("Operation operand is wrong.");
  chk_lock_sel: assert property (wr_cp && cp_num == `SC_CP_LOCK && bank == `SC_BANK_1 |=> ilock_q == $past(i_pwdata)
    && $stable(dlock_q))
    else $error("Instruction lockdown write went astray.");
  chk_tcm_sel: assert property (wr_cp && cp_num == `SC_CP_LOCK && bank == `SC_BANK_3 |=> itcm_q == $past(i_pwdata))
    else $error("Instruction memory control write went astray.");
  chk_op_ignore: assert property (wr_cp && cp_num == `SC_CP_CACHEOP && bank[1] |=> !o_cache_cmd.valid)
    else $error("Unlisted operation started a command.");
  chk_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("Ready stood longer than one cycle.");

  cov_op_issued: cover property (o_cache_cmd.valid);
  cov_region_wr: cover property (wr_cp && cp_num == `SC_CP_REGION);
  cov_err_answer: cover property (o_pready && o_pslverr);
  cov_b2b: cover property (commit ##1 (i_psel && !i_penable) ##2 commit);
endmodule : sysctl_coproc_reg_decode

/* File: sysctl_coproc_reg_decode_tb.sv */
`timescale 1ns/1ps
`include "sysctl_coproc_defs.svh"
`define CHK(nm, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("BAD %s expected %h seen %h", nm, exp, got); \
    end \
  end

// ============================================================
// Bench for the coprocessor register decoder.
module sysctl_coproc_reg_decode_tb;
  import sysctl_coproc_pkg::*;
  localparam logic [31:0] ID_VAL  = 32'h1D1D_0001; // Arbitrary value.
  localparam logic [31:0] CFG_VAL = 32'h0C0C_0002; // Arbitrary value.
  localparam logic [31:0] TCM_VAL = 32'h07C7_0003; // Arbitrary value.
  logic        core_clk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rdv;
  logic        errv;
  cache_cmd_t  cmd;
  cache_cmd_t  cmd_last;
  int          failures;
  int          checks_done;
  int          cmd_n;

  sysctl_coproc_reg_decode #(.NUM_REGIONS(8), .ID_VALUE(ID_VAL), .CACHE_CFG_VALUE(CFG_VAL),
    .TCM_INFO_VALUE(TCM_VAL)) i_sysctl_coproc_reg_decode (.i_core_clk(core_clk), .i_resetn(resetn),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata), .o_cache_cmd(cmd));

  sysctl_apb_host i_sysctl_apb_host (.i_core_clk(core_clk), .i_pready(pready), .i_pslverr(pslverr),
    .i_prdata(prdata), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
    .o_pwdata(pwdata));

  // The clock toggles every half period of 5 ns.
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  // Every cache command pulse is counted and kept.
  always @(posedge core_clk)
  begin
    if (resetn === 1'b1 && cmd.valid === 1'b1)
    begin
      cmd_n    <= cmd_n + 1;
      cmd_last <= cmd;
    end
  end

  // ============================================================
  // Access tasks.
  function automatic logic [7:0] ra(input logic [3:0] n);
    return {2'b00, n, 2'b00};
  endfunction : ra

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    i_sysctl_apb_host.xfer(1'b1, a, d, rdv, errv);
    `CHK("write error flag", e, errv)
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic e);
    i_sysctl_apb_host.xfer(1'b0, a, 32'h0000_0000, rdv, errv);
    `CHK("read error flag", e, errv)
    if (!e) `CHK("read data", x, rdv)
  endtask : rd

  task automatic bank(input logic [1:0] b, input logic [2:0] r);
    wr(`SC_SEL_OFS, {27'h000_0000, r, b}, 1'b0);
  endtask : bank

  task automatic tally_and_finish;
    if (failures == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // A hang is cut short well beyond the length of the run.
  initial
  begin
    repeat (20000) @(posedge core_clk);
    failures++;
    tally_and_finish();
  end

  // ============================================================
  // Main sequence.
  initial
  begin
    int          n0;
    logic        listed;
    logic [31:0] d;
    resetn = 1'b0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    `CHK("ready in reset", 1'b0, pready)
    `CHK("command in reset", 37'h00_0000_0000, cmd)
    bank(2'h0, 3'h0);
    rd(ra(`SC_CP_ID), ID_VAL, 1'b0);
    wr(ra(`SC_CP_ID), 32'hFFFF_FFFF, 1'b1);
    rd(ra(`SC_CP_ID), ID_VAL, 1'b0);
    bank(2'h1, 3'h0);
    rd(ra(`SC_CP_ID), CFG_VAL, 1'b0);
    bank(2'h2, 3'h0);
    rd(ra(`SC_CP_ID), TCM_VAL, 1'b0);
    bank(2'h3, 3'h0);
    rd(ra(`SC_CP_ID), 32'h0000_0000, 1'b1);
    wr(ra(`SC_CP_CTRL), 32'h5A5A_0001, 1'b0);
    wr(ra(`SC_CP_BUF), 32'h5A5A_0003, 1'b0);
    wr(ra(`SC_CP_TRACE), 32'h5A5A_000D, 1'b0);
    bank(2'h0, 3'h0);
    rd(ra(`SC_CP_CTRL), 32'h5A5A_0001, 1'b0);
    rd(ra(`SC_CP_BUF), 32'h5A5A_0003, 1'b0);
    rd(ra(`SC_CP_TRACE), 32'h5A5A_000D, 1'b0);
    // Banked registers: later banks overwrite the side they alias to.
    for (int b = 0; b < 4; b++)
    begin
      bank(2'(b), 3'h0);
      wr(ra(`SC_CP_CACHE), 32'h2000_0000 + b, 1'b0);
      wr(ra(`SC_CP_PROT), 32'h5000_0000 + b, b == 3);
      wr(ra(`SC_CP_LOCK), 32'h9000_0000 + b, 1'b0);
    end
    for (int b = 0; b < 4; b++)
    begin
      bank(2'(b), 3'h0);
      rd(ra(`SC_CP_CACHE), 32'h2000_0002 + b % 2, 1'b0);
      rd(ra(`SC_CP_PROT), (b == 1) ? 32'h5000_0001 : 32'h5000_0002, b == 3);
      rd(ra(`SC_CP_LOCK), 32'h9000_0000 + b, 1'b0);
    end
    // Regions written on one side are read back on the other side.
    for (int r = 0; r < 8; r++)
    begin
      bank(2'(r % 2), 3'(r));
      wr(ra(`SC_CP_REGION), 32'h6000_0000 + r * 32'h0011_0000, 1'b0);
    end
    for (int r = 0; r < 8; r++)
    begin
      bank(2'((r + 1) % 2), 3'(r));
      rd(ra(`SC_CP_REGION), 32'h6000_0000 + r * 32'h0011_0000, 1'b0);
    end
    // Every bank and code pair on the cache operation register.
    for (int b = 0; b < 4; b++)
    begin
      bank(2'(b), 3'h0);
      for (int c = 0; c < 8; c++)
      begin
        n0 = cmd_n;
        d = {29'(32'h1000_0000 + b * 8 + c), 3'(c)};
        wr(ra(`SC_CP_CACHEOP), d, 1'b0);
        @(posedge core_clk);
        #1;
        listed = (b == 0 && c < 6) || (b == 1 && c < 3);
        `CHK("command count", 32'(n0 + listed), 32'(cmd_n))
        if (listed)
        begin
          `CHK("command op", 4'((b == 0) ? c + 1 : c + 7), cmd_last.op)
          `CHK("command operand", {d[31:3], 3'b000}, cmd_last.operand)
        end
      end
    end
    rd(ra(`SC_CP_CACHEOP), 32'h0000_0000, 1'b1);
    rd(ra(4'h4), 32'h0000_0000, 1'b1);
    rd(8'h44, 32'h0000_0000, 1'b1);
    wr(8'hFC, 32'h0000_0000, 1'b1);
    // A second reset in mid-run clears storage and the selector.
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    rd(ra(`SC_CP_CTRL), 32'h0000_0000, 1'b0);
    rd(ra(`SC_CP_ID), ID_VAL, 1'b0);
    tally_and_finish();
  end
endmodule : sysctl_coproc_reg_decode_tb
